// *** pgt_gate_timer.sv ***
// Top of the per-lane pattern-checker gate timer block with its APB register slave.
// Assumes APB master on the same clock; error events arrive synchronous, one bit per lane.
`timescale 1ns/1ns
module pgt_gate_timer #(
	parameter int NUM_BANKS    = pgt_pkg::NUM_BANKS,
	parameter int LANES        = pgt_pkg::LANES,
	parameter int CNT_W        = pgt_pkg::CNT_W,
	parameter int SEC_CYCLES   = pgt_pkg::SEC_CYCLES,
	parameter bit CAP_AUTO     = 1'b1,
	parameter bit CAP_REALTIME = 1'b1,
	parameter bit CAP_PER_LANE = 1'b1
) (
	// System
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	// APB slave
	input  wire logic [11:0]                paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// Checker error events
	input  wire logic [NUM_BANKS*LANES-1:0] hostErr,
	input  wire logic [NUM_BANKS*LANES-1:0] mediaErr
);
	localparam int NL     = NUM_BANKS * 2 * LANES;
	localparam int BANK_W = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;
	localparam int LW     = $clog2(2 * LANES);
	localparam int NLW    = $clog2(NL);
	localparam int SEC_W  = $clog2(SEC_CYCLES);
	localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_CYCLES - 1);

	// Lanes of one side, for shared-timer mode
	function automatic logic [NL-1:0] side_mask(input logic media);
		logic [NL-1:0] m;
		m = '0;
		for (int l = 0; l < NL; l++) begin
			m[l] = (((l / LANES) % 2) == 1) == media;
		end
		return m;
	endfunction

	localparam logic [NL-1:0] HOST_MASK  = side_mask(1'b0);
	localparam logic [NL-1:0] MEDIA_MASK = side_mask(1'b1);

	// Bank addressed by the bank select register
	function automatic logic bank_hit(input int b, input logic [BANK_W-1:0] sel);
		return BANK_W'(b) == sel;
	endfunction

	// First lane index of one side of one bank
	function automatic int lane_base(input int b, input int side);
		return b * 2 * LANES + side * LANES;
	endfunction

	// Reset release
	logic                 rstMeta;
	logic                 rstN;

	// Time base
	logic [SEC_W-1:0]     secCnt;
	logic                 secTick;

	// Registers
	logic [BANK_W-1:0]    bankSel;
	logic [7:0]           gateCtrl  [NUM_BANKS];
	logic [LANES-1:0]     hostEn    [NUM_BANKS];
	logic [LANES-1:0]     mediaEn   [NUM_BANKS];
	logic [LANES-1:0]     flagHost  [NUM_BANKS];
	logic [LANES-1:0]     flagMedia [NUM_BANKS];
	logic [7:0]           resSel;
	logic                 freezeReg;
	logic [NUM_BANKS-1:0] restartMask;
	logic [NL-1:0]        laneEnD;

	// Lane wiring
	logic [NL-1:0]        laneEn;
	logic [NL-1:0]        laneDone;
	logic [CNT_W-1:0]     resArr  [NL];
	logic [CNT_W-1:0]     prevArr [NL];
	logic [NUM_BANKS-1:0] next_restartMask;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta <= 1'b0;
			rstN    <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN    <= rstMeta;
		end
	end

	// One-second enable pulse
	wire secWrap = (secCnt == SEC_LAST);

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			secCnt  <= '0;
			secTick <= 1'b0;
		end else begin
			secCnt  <= secWrap ? '0 : secCnt + {{(SEC_W-1){1'b0}}, 1'b1};
			secTick <= secWrap;
		end
	end

	// APB decode
	wire [7:0] idx       = paddr[9:2];
	wire       accessPh  = psel && penable;
	wire       prepPh    = accessPh && !pready;
	wire       doneWr    = accessPh && pready && pwrite;
	wire       doneRd    = accessPh && pready && !pwrite;
	wire       hitBank   = (idx == pgt_pkg::IDX_BANK_SEL);
	wire       hitCaps   = (idx == pgt_pkg::IDX_CAPS);
	wire       hitFlagH  = (idx == pgt_pkg::IDX_FLAG_HOST);
	wire       hitFlagM  = (idx == pgt_pkg::IDX_FLAG_MEDIA);
	wire       hitHostEn = (idx == pgt_pkg::IDX_HOST_EN);
	wire       hitMedEn  = (idx == pgt_pkg::IDX_MEDIA_EN);
	wire       hitGate   = (idx == pgt_pkg::IDX_GATE_CTRL);
	wire       hitResSel = (idx == pgt_pkg::IDX_RES_SEL);
	wire       hitResDat = (idx == pgt_pkg::IDX_RES_DATA);
	wire       hitAny    = (paddr[11:10] == 2'h0) && (hitBank || hitCaps || hitFlagH || hitFlagM ||
		hitHostEn || hitMedEn || hitGate || hitResSel || hitResDat);

	// Capability byte
	wire [7:0] caps = (8'(CAP_AUTO) << pgt_pkg::CAP_AUTO_BIT) |
		(8'(CAP_PER_LANE) << pgt_pkg::CAP_PERLANE_BIT) |
		(8'(CAP_REALTIME) << pgt_pkg::CAP_REALTIME_BIT);

	// Result readback for the current bank
	wire [NLW-1:0]   selIdx  = NLW'(bankSel * (2 * LANES) + resSel[LW-1:0]);
	wire [CNT_W-1:0] selRes  = resSel[pgt_pkg::RS_PREV_BIT] ? prevArr[selIdx] : resArr[selIdx];
	wire [7:0]       curGate = gateCtrl[bankSel];

	wire [31:0] rdData =
		hitBank   ? 32'(bankSel) :
		hitCaps   ? {24'h0, caps} :
		hitFlagH  ? 32'(flagHost[bankSel]) :
		hitFlagM  ? 32'(flagMedia[bankSel]) :
		hitHostEn ? 32'(hostEn[bankSel]) :
		hitMedEn  ? 32'(mediaEn[bankSel]) :
		hitGate   ? {24'h0, curGate} :
		hitResSel ? {24'h0, resSel} :
		hitResDat ? 32'(selRes) : 32'h0;

	// Only bits actually returned are cleared
	wire [LANES-1:0] clrHost  = (doneRd && hitFlagH) ? prdata[LANES-1:0] : '0;
	wire [LANES-1:0] clrMedia = (doneRd && hitFlagM) ? prdata[LANES-1:0] : '0;

	// Reset bit falling on a gate control write
	wire gateWr    = doneWr && hitGate;
	wire resetFall = gateWr && curGate[pgt_pkg::GC_RESET_ERR] && !pwdata[pgt_pkg::GC_RESET_ERR];

	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		wire isCur = bank_hit(b, bankSel);
		wire flagged = isCur ? pwdata[pgt_pkg::GC_ALL_BANKS] : gateCtrl[b][pgt_pkg::GC_ALL_BANKS];
		assign next_restartMask[b] = resetFall && (pwdata[pgt_pkg::GC_ALL_BANKS] ? flagged : isCur);
	end

	// APB answer, one wait state
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= prepPh;
			pslverr <= prepPh && !hitAny;
			if (prepPh) begin
				prdata <= (pwrite || !hitAny) ? 32'h0 : rdData;
			end
		end
	end

	// Register writes
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			bankSel   <= '0;
			resSel    <= pgt_pkg::RS_RESET;
			freezeReg <= 1'b0;
			for (int b = 0; b < NUM_BANKS; b++) begin
				gateCtrl[b] <= pgt_pkg::GC_RESET;
				hostEn[b]   <= '0;
				mediaEn[b]  <= '0;
			end
		end else if (doneWr && hitAny) begin
			if (hitBank) begin
				bankSel <= pwdata[BANK_W-1:0];
			end
			if (hitResSel) begin
				resSel <= pwdata[7:0];
			end
			if (hitGate) begin
				gateCtrl[bankSel] <= pwdata[7:0] & pgt_pkg::GC_WR_MASK;
				freezeReg         <= pwdata[pgt_pkg::GC_RESET_ERR];
			end
			if (hitHostEn) begin
				hostEn[bankSel] <= pwdata[LANES-1:0];
			end
			if (hitMedEn) begin
				mediaEn[bankSel] <= pwdata[LANES-1:0];
			end
		end
	end

	// Restart events
	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			restartMask <= '0;
			laneEnD     <= '0;
		end else begin
			restartMask <= next_restartMask;
			laneEnD     <= laneEn;
		end
	end

	// Sticky clear-on-read flags, set wins over clear
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_flag
		wire             isSel = bank_hit(b, bankSel);
		wire [LANES-1:0] doneH = laneDone[lane_base(b, 0) +: LANES];
		wire [LANES-1:0] doneM = laneDone[lane_base(b, 1) +: LANES];
		wire [LANES-1:0] keepH = flagHost[b] & ~(isSel ? clrHost : {LANES{1'b0}});
		wire [LANES-1:0] keepM = flagMedia[b] & ~(isSel ? clrMedia : {LANES{1'b0}});

		always_ff @(posedge clock or negedge rstN) begin
			if (!rstN) begin
				flagHost[b]  <= '0;
				flagMedia[b] <= '0;
			end else begin
				flagHost[b]  <= keepH | doneH;
				flagMedia[b] <= keepM | doneM;
			end
		end
	end

	// Lane start requests
	logic [NL-1:0] startRaw;
	wire  [NL-1:0] shareH = (|(startRaw & HOST_MASK)) ? (laneEn & HOST_MASK) : '0;
	wire  [NL-1:0] shareM = (|(startRaw & MEDIA_MASK)) ? (laneEn & MEDIA_MASK) : '0;
	wire  [NL-1:0] laneStart = CAP_PER_LANE ? startRaw : (startRaw | shareH | shareM);

	for (genvar l = 0; l < NL; l++) begin : g_lane
		localparam int B = l / (2 * LANES);
		localparam int M = (l / LANES) % 2;
		localparam int K = l % LANES;

		pgt_lane_if #(.CNT_W(CNT_W)) lif ();

		assign laneEn[l]       = (M == 1) ? mediaEn[B][K] : hostEn[B][K];
		assign startRaw[l]     = laneEn[l] && (!laneEnD[l] || restartMask[B]);
		assign lif.enable      = laneEn[l];
		assign lif.start       = laneStart[l];
		assign lif.freeze      = freezeReg;
		assign lif.secTick     = secTick;
		assign lif.errInc      = (M == 1) ? mediaErr[B*LANES+K] : hostErr[B*LANES+K];
		assign lif.autoRestart = CAP_AUTO && gateCtrl[B][pgt_pkg::GC_AUTO];
		assign lif.realTime    = CAP_REALTIME;
		assign lif.gateSecs    = gateCtrl[B][pgt_pkg::GC_TIME_HI:pgt_pkg::GC_TIME_LO];
		assign lif.updSecs     = gateCtrl[B][pgt_pkg::GC_UPD] ? pgt_pkg::UPD_SECS_Y1 : pgt_pkg::UPD_SECS_Y0;
		assign laneDone[l]     = lif.expired;
		assign resArr[l]       = lif.result;
		assign prevArr[l]      = lif.previous;

		pgt_lane_gate #(
			.CNT_W (CNT_W)
		) u_gate (
			.clock (clock),
			.rstN  (rstN),
			.lif   (lif)
		);
	end
endmodule // pgt_gate_timer

// *** pgt_gate_timer_sva.sv ***
// Checker of the gate timer block: APB answer timing and register read values.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module pgt_gate_timer_sva #(
	parameter bit CAP_AUTO     = 1'b1,
	parameter bit CAP_REALTIME = 1'b1,
	parameter bit CAP_PER_LANE = 1'b1
) (
	// System
	input wire logic        clock,
	input wire logic        rst_n,
	// APB
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// First access cycle, then a read of one index
	sequence s_acc;
		psel && penable && !pready;
	endsequence
	sequence s_rd(logic [7:0] idx);
		s_acc ##0 (!pwrite && paddr[11:2] == {2'b00, idx});
	endsequence

	AST_ONE_WAIT: assert property (s_acc |=> pready) else $error("No answer after access");
	AST_PULSE: assert property (pready |=> !pready) else $error("Answer longer than one cycle");
	AST_ERR_READY: assert property (pslverr |-> pready && psel && penable) else $error("Stray error");
	AST_UNMAPPED: assert property ((s_acc ##0 paddr[11:10] != 2'b00) |=> pslverr && prdata == 32'h0)
		else $error("Unmapped access not refused");
	AST_WR_ZERO: assert property (pready && pwrite |-> prdata == 32'h0) else $error("Write returned data");
	AST_HOLD: assert property (!pready |-> $stable(prdata)) else $error("Read data moved");
	AST_GATE_OK: assert property ((s_acc ##0 paddr[11:2] == {2'b00, pgt_pkg::IDX_GATE_CTRL}) |=> !pslverr)
		else $error("Gate control refused");
	AST_GATE_BYTE: assert property (s_rd(pgt_pkg::IDX_GATE_CTRL) |=> prdata[31:8] == 24'h0 && !prdata[6])
		else $error("Gate control read wrong");
	AST_CAPS: assert property (s_rd(pgt_pkg::IDX_CAPS) |=> prdata[4:2] == {CAP_REALTIME, CAP_PER_LANE, CAP_AUTO})
		else $error("Capability bits wrong");
	AST_FLAG_BYTE: assert property (s_rd(pgt_pkg::IDX_FLAG_HOST) |=> prdata[31:8] == 24'h0)
		else $error("Flag read too wide");
endmodule // pgt_gate_timer_sva

bind pgt_gate_timer pgt_gate_timer_sva #(.CAP_AUTO(CAP_AUTO), .CAP_REALTIME(CAP_REALTIME),
	.CAP_PER_LANE(CAP_PER_LANE)) i_pgt_gate_timer_sva (.clock, .rst_n, .paddr, .psel, .penable, .pwrite,
	.prdata, .pready, .pslverr);

// *** pgt_host_model.sv ***
// Host model: APB master reaching the gate timer registers.
// Assumes one clock shared with the slave, which answers with pready.
`timescale 1ns/1ns
module pgt_host_model (
	// System
	input  wire logic        clock,
	// APB master
	output logic      [11:0] paddr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		paddr   = 12'h0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		pwdata  = 32'h0;
	end

	// One transfer; released address and data lines show the inverse of the last value, pwrite keeps it
	task automatic xfer(input logic w, input logic [9:0] wa, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge clock);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= {wa, 2'b00};
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~{wa, 2'b00};
		pwdata  <= ~wd;
	endtask
endmodule // pgt_host_model

// *** pgt_lane_gate.sv ***
// Gate timer and error counters of one checker lane.
// Assumes a one-second tick pulse and synchronous error events.
`timescale 1ns/1ns
module pgt_lane_gate #(
	parameter int CNT_W = pgt_pkg::CNT_W
) (
	// System
	input wire logic clock,
	input wire logic rstN,
	// Lane controls and results
	pgt_lane_if.timer lif
);
	pgt_pkg::pgt_state_t state;
	logic [2:0]       timer;
	logic [2:0]       updCnt;
	logic [CNT_W-1:0] live;

	wire              running   = (state == pgt_pkg::PGT_RUN) && lif.enable && !lif.freeze;
	wire              gated     = (lif.gateSecs != 3'h0);
	wire [2:0]        timerInc  = timer + 3'h1;
	wire [2:0]        updInc    = updCnt + 3'h1;
	wire [CNT_W-1:0]  liveNext  = (running && lif.errInc && !(&live)) ? live + {{(CNT_W-1){1'b0}}, 1'b1} : live;
	wire              expireNow = running && gated && lif.secTick && (timerInc == lif.gateSecs);
	wire              updDue    = running && lif.realTime && lif.secTick && (updInc == lif.updSecs);

	always_ff @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			state        <= pgt_pkg::PGT_IDLE;
			timer        <= 3'h0;
			updCnt       <= 3'h0;
			live         <= '0;
			lif.result   <= '0;
			lif.previous <= '0;
			lif.expired  <= 1'b0;
		end else begin
			lif.expired <= expireNow;
			if (lif.start) begin
				state      <= pgt_pkg::PGT_RUN;
				timer      <= 3'h0;
				updCnt     <= 3'h0;
				live       <= '0;
				lif.result <= '0;
			end else if (expireNow) begin
				lif.result <= liveNext;
				timer      <= 3'h0;
				updCnt     <= 3'h0;
				if (lif.autoRestart) begin
					lif.previous <= liveNext;
					live         <= '0;
				end else begin
					state <= pgt_pkg::PGT_DONE;
					live  <= liveNext;
				end
			end else if (running) begin
				live <= liveNext;
				if (lif.secTick) begin
					timer  <= gated ? timerInc : timer;
					updCnt <= updDue ? 3'h0 : updInc;
				end
				if (updDue || !gated) begin
					lif.result <= liveNext;
				end
			end
		end
	end
endmodule // pgt_lane_gate

// *** pgt_lane_if.sv ***
// Signals between the control core and one lane gate timer.
// Assumes one instance per lane, driven by the top module.
`timescale 1ns/1ns
interface pgt_lane_if #(
	parameter int CNT_W = pgt_pkg::CNT_W
);
	logic             enable;
	logic             start;
	logic             freeze;
	logic             secTick;
	logic             errInc;
	logic             autoRestart;
	logic             realTime;
	logic [2:0]       gateSecs;
	logic [2:0]       updSecs;
	logic [CNT_W-1:0] result;
	logic [CNT_W-1:0] previous;
	logic             expired;

	modport timer (input enable, start, freeze, secTick, errInc, autoRestart, realTime, gateSecs, updSecs,
		output result, previous, expired);
	modport ctrl (output enable, start, freeze, secTick, errInc, autoRestart, realTime, gateSecs, updSecs,
		input result, previous, expired);
endinterface

// *** pgt_pkg.sv ***
// Shared constants for the per-lane pattern-checker gate timer block.
// Assumes a single 250 MHz clock; register indices are word indices on APB.
package pgt_pkg;

	// Geometry defaults
	localparam int NUM_BANKS = 4;
	localparam int LANES     = 8;
	localparam int CNT_W     = 32;

	// Register indices, byte address is four times the index
	localparam logic [7:0] IDX_BANK_SEL   = 8'h7e;
	localparam logic [7:0] IDX_CAPS       = 8'h81;
	localparam logic [7:0] IDX_FLAG_HOST  = 8'h86;
	localparam logic [7:0] IDX_FLAG_MEDIA = 8'h87;
	localparam logic [7:0] IDX_HOST_EN    = 8'ha0;
	localparam logic [7:0] IDX_MEDIA_EN   = 8'ha8;
	localparam logic [7:0] IDX_GATE_CTRL  = 8'hb1;
	localparam logic [7:0] IDX_RES_SEL    = 8'hf0;
	localparam logic [7:0] IDX_RES_DATA   = 8'hf1;

	// Gate control fields
	localparam int GC_ALL_BANKS = 7;
	localparam int GC_RESET_ERR = 5;
	localparam int GC_AUTO      = 4;
	localparam int GC_TIME_HI   = 3;
	localparam int GC_TIME_LO   = 1;
	localparam int GC_UPD       = 0;
	localparam logic [7:0] GC_WR_MASK = 8'hbf;
	localparam logic [7:0] GC_RESET   = 8'h00;

	// Capability fields
	localparam int CAP_AUTO_BIT     = 2;
	localparam int CAP_PERLANE_BIT  = 3;
	localparam int CAP_REALTIME_BIT = 4;

	// Result selector fields
	localparam int RS_PREV_BIT = 4;
	localparam logic [7:0] RS_RESET = 8'h00;

	// Time base
	localparam int CLK_PERIOD_NS = 4;
	localparam int SEC_NS        = 1_000_000_000;
	localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
	localparam logic [2:0] UPD_SECS_Y0 = 3'h1;
	localparam logic [2:0] UPD_SECS_Y1 = 3'h2;

	typedef enum logic [1:0] {
		PGT_IDLE = 2'b00,
		PGT_RUN  = 2'b01,
		PGT_DONE = 2'b11
	} pgt_state_t;

endpackage

// *** testbench.sv ***
// Testbench of the gate timer block: registers, gating, freeze and auto-restart.
// Assumes the host model as APB master and a shortened one-second count.
`timescale 1ns/1ns
module testbench;
	localparam int SECS = 20;
	logic        clock;
	logic        rst_n;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] hostErr;
	logic [31:0] mediaErr;
	logic [31:0] rd;
	logic        er;
	int          bad_count;
	int          samples_checked;

	pgt_gate_timer #(.SEC_CYCLES(SECS)) i_pgt_gate_timer (.clock, .rst_n, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .hostErr, .mediaErr);
	pgt_host_model i_pgt_host_model (.clock, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr);

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic report_and_stop;
		$display("Checked %0d, errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		i_pgt_host_model.xfer(1'b1, {2'b00, idx}, {24'h0, d}, rd, er);
	endtask

	task automatic rdx(input logic [7:0] idx);
		i_pgt_host_model.xfer(1'b0, {2'b00, idx}, 32'h0, rd, er);
	endtask

	// Error pulses, starting once a preceding restart has landed
	task automatic errs(input logic [31:0] hm, input logic [31:0] mm, input int n);
		repeat (2) @(posedge clock);
		repeat (n) begin
			@(posedge clock);
			hostErr  <= hm;
			mediaErr <= mm;
			@(posedge clock);
			hostErr  <= 32'h0;
			mediaErr <= 32'h0;
		end
	endtask

	task automatic waitFlag(input logic [7:0] idx, input logic [7:0] msk);
		int n;
		n = 0;
		do begin
			rdx(idx);
			n++;
		end while ((rd[7:0] & msk) == 8'h0 && n < 60);
		chk({24'h0, rd[7:0] & msk}, {24'h0, msk});
	endtask

	task automatic readRes(input logic [7:0] sel, input logic [31:0] exp);
		wr(pgt_pkg::IDX_RES_SEL, sel);
		rdx(pgt_pkg::IDX_RES_DATA);
		chk(rd, exp);
	endtask

	task automatic t_regs;
		rdx(pgt_pkg::IDX_GATE_CTRL);
		chk(rd, {24'h0, pgt_pkg::GC_RESET});
		wr(pgt_pkg::IDX_GATE_CTRL, 8'hff);
		rdx(pgt_pkg::IDX_GATE_CTRL);
		chk(rd, {24'h0, pgt_pkg::GC_WR_MASK});
		wr(pgt_pkg::IDX_GATE_CTRL, 8'h00);
		rdx(pgt_pkg::IDX_CAPS);
		chk({29'h0, rd[4:2]}, 32'h7);
		rdx(8'h10);
		chk({31'h0, er}, 32'h1);
		i_pgt_host_model.xfer(1'b0, 10'h3b1, 32'h0, rd, er);
		chk({rd[30:0], er}, 32'h1);
	endtask

	task automatic t_gated(input logic [7:0] bank, input logic side, input int lane);
		logic [31:0] m;
		logic [7:0]  en;
		logic [7:0]  fi;
		m  = 32'h1 << (bank * 8 + lane);
		en = 8'h1 << lane;
		fi = side ? pgt_pkg::IDX_FLAG_MEDIA : pgt_pkg::IDX_FLAG_HOST;
		wr(pgt_pkg::IDX_BANK_SEL, bank);
		wr(pgt_pkg::IDX_GATE_CTRL, 8'h04);
		wr(side ? pgt_pkg::IDX_MEDIA_EN : pgt_pkg::IDX_HOST_EN, en);
		errs(side ? 32'h0 : m, side ? m : 32'h0, 5);
		waitFlag(fi, en);
		rdx(fi);
		chk({24'h0, rd[7:0] & en}, 32'h0);
		errs(side ? 32'h0 : m, side ? m : 32'h0, 3);
		readRes({4'h0, side, lane[2:0]}, 32'd5);
		wr(side ? pgt_pkg::IDX_MEDIA_EN : pgt_pkg::IDX_HOST_EN, 8'h00);
	endtask

	task automatic t_freeze(input logic [7:0] bank, input logic [7:0] top);
		wr(pgt_pkg::IDX_BANK_SEL, bank);
		wr(pgt_pkg::IDX_GATE_CTRL, top | 8'h08);
		wr(pgt_pkg::IDX_HOST_EN, 8'h08);
		errs(32'h8 << (bank * 8), 32'h0, 3);
		wr(pgt_pkg::IDX_BANK_SEL, 8'h00);
		wr(pgt_pkg::IDX_GATE_CTRL, top | 8'h28);
		errs(32'h8 << (bank * 8), 32'h0, 6);
		repeat (100) @(posedge clock);
		wr(pgt_pkg::IDX_BANK_SEL, bank);
		rdx(pgt_pkg::IDX_FLAG_HOST);
		chk({24'h0, rd[7:0] & 8'h08}, 32'h0);
		wr(pgt_pkg::IDX_BANK_SEL, 8'h00);
		wr(pgt_pkg::IDX_GATE_CTRL, top | 8'h08);
		errs(32'h8 << (bank * 8), 32'h0, 2);
		wr(pgt_pkg::IDX_BANK_SEL, bank);
		waitFlag(pgt_pkg::IDX_FLAG_HOST, 8'h08);
		readRes(8'h03, 32'd2);
		wr(pgt_pkg::IDX_HOST_EN, 8'h00);
	endtask

	task automatic t_auto;
		wr(pgt_pkg::IDX_BANK_SEL, 8'h00);
		wr(pgt_pkg::IDX_GATE_CTRL, 8'h14);
		wr(pgt_pkg::IDX_HOST_EN, 8'h04);
		errs(32'h4, 32'h0, 6);
		waitFlag(pgt_pkg::IDX_FLAG_HOST, 8'h04);
		errs(32'h4, 32'h0, 4);
		waitFlag(pgt_pkg::IDX_FLAG_HOST, 8'h04);
		readRes(8'h12, 32'd4);
		wr(pgt_pkg::IDX_HOST_EN, 8'h00);
		wr(pgt_pkg::IDX_GATE_CTRL, 8'h00);
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		report_and_stop();
	end

	initial begin
		bad_count = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		hostErr = 32'h0;
		mediaErr = 32'h0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		t_regs();
		t_gated(8'h00, 1'b0, 0);
		t_gated(8'h01, 1'b1, 1);
		t_freeze(8'h00, 8'h00);
		t_freeze(8'h02, 8'h80);
		t_auto();
		report_and_stop();
	end
endmodule // testbench
